//--- rtl/channel_pair_config_frames.sv
// configuration frames for channels seven and eight
//
// Function
// R1 - channel-eight frame code 1000 in top bits
// R2 - read/write bit: 0 writes, 1 reads only
// R3 - bit zero is even parity over frame; the code sets it so the whole frame holds an odd count of ones
// R4 - bridge enable groups channels five to eight
// R5 - masking bit picks peak-hold open-load report
// R6 - peak-hold enable configures channels five to eight
// R7 - two-bit off-state diagnostic time, resets 11
// R8 - diagnostic time ignored if bridge without extension
// R9 - readback select: fixed or compensated threshold
// R10 - six-bit overcurrent threshold, resets zero
// R11 - two-bit temperature compensation, resets 00
// R12 - battery compensation bit, resets zero
// R13 - three-bit overcurrent blanking time table
// R14 - shunt mode: blanking only times diagnostic
// R15 - re-engagement strategy after overcurrent shutdown
// R16 - sense method: drain-source or shunt
// R17 - open-load current: 100 uA or 1 mA
// R18 - two-bit gate current select, resets 00
// R19 - n- or p-channel for high side
// R20 - side select: low or high side
// R21 - output enable bit, resets off
// R22 - all fields reset on power-on and pin
`timescale 1ns/10ps
`default_nettype none
module channel_pair_config_frames #(
    parameter int TDIAG2_CYC = cfg_frame_pkg::TDIAG2_NS / cfg_frame_pkg::CLK_PERIOD_NS,
    parameter int TDIAG3_CYC = cfg_frame_pkg::TDIAG3_NS / cfg_frame_pkg::CLK_PERIOD_NS,
    parameter int BLANK7_CYC = cfg_frame_pkg::BLANK7_NS / cfg_frame_pkg::CLK_PERIOD_NS
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic external_reset_low_in,
    input wire logic sck_in,
    input wire logic cs_low_in,
    input wire logic mosi_in,
    input wire logic bridge2_tdiag_ext_in,
    output logic miso_out,
    output logic miso_oe_out,
    output logic second_bridge_enable_out,
    output logic second_peak_hold_enable_out,
    output logic second_peak_hold_openload_masking_out,
    output logic [3:0] bridge_group_out,
    output logic [3:0] peak_hold_group_out,
    output logic openload_no_diag_report_out,
    output logic [1:0] tdiag_select_out,
    output logic [1:0] tdiag_active_out,
    output logic [1:0][12:0] tdiag_cycles_out,
    output logic [1:0] threshold_readback_select_out,
    output logic [1:0][5:0] overcurrent_threshold_out,
    output logic [1:0][1:0] temperature_compensation_out,
    output logic [1:0] battery_compensation_out,
    output logic [1:0][2:0] overcurrent_blanking_out,
    output logic [1:0][12:0] oc_blank_cycles_out,
    output logic [1:0] vds_blanking_active_out,
    output logic [1:0] reengage_strategy_out,
    output logic [1:0] sense_method_select_out,
    output logic [1:0] openload_current_high_out,
    output logic [1:0][1:0] gate_current_select_out,
    output logic [1:0] pchannel_select_out,
    output logic [1:0] side_select_out,
    output logic [1:0] output_enable_out
);
    localparam int CW = cfg_frame_pkg::CYC_W;
    localparam int TDIAG0_CYC = cfg_frame_pkg::TDIAG0_NS / cfg_frame_pkg::CLK_PERIOD_NS;
    localparam int TDIAG1_CYC = cfg_frame_pkg::TDIAG1_NS / cfg_frame_pkg::CLK_PERIOD_NS;
    localparam int BLANK0_CYC = cfg_frame_pkg::BLANK0_NS / cfg_frame_pkg::CLK_PERIOD_NS;
    localparam int BLANK1_CYC = cfg_frame_pkg::BLANK1_NS / cfg_frame_pkg::CLK_PERIOD_NS;
    localparam int BLANK2_CYC = cfg_frame_pkg::BLANK2_NS / cfg_frame_pkg::CLK_PERIOD_NS;
    localparam int BLANK3_CYC = cfg_frame_pkg::BLANK3_NS / cfg_frame_pkg::CLK_PERIOD_NS;
    localparam int BLANK4_CYC = cfg_frame_pkg::BLANK4_NS / cfg_frame_pkg::CLK_PERIOD_NS;
    localparam int BLANK5_CYC = cfg_frame_pkg::BLANK5_NS / cfg_frame_pkg::CLK_PERIOD_NS;
    localparam int BLANK6_CYC = cfg_frame_pkg::BLANK6_NS / cfg_frame_pkg::CLK_PERIOD_NS;

    // ****************************************
    // helpers
    // ****************************************
    // odd parity: one when the other 31 bits hold an even count of ones
    function automatic logic parity_of(input logic [31:0] w);
        parity_of = ~(^w[31:1]); // see R3
    endfunction

    // stored image: own code, read bit shown as one, fresh parity
    function automatic logic [31:0] make_image(input logic [3:0] code, input logic [31:0] w);
        logic [31:0] t;
        t = {code, 1'b1, w[cfg_frame_pkg::CFG_HI:cfg_frame_pkg::CFG_LO], 1'b0};
        t[cfg_frame_pkg::PARITY_BIT] = parity_of(t);
        make_image = t;
    endfunction

    function automatic logic [CW-1:0] tdiag_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: tdiag_cycles = CW'(TDIAG0_CYC);
            2'h1: tdiag_cycles = CW'(TDIAG1_CYC);
            2'h2: tdiag_cycles = CW'(TDIAG2_CYC);
            2'h3: tdiag_cycles = CW'(TDIAG3_CYC);
        endcase
    endfunction

    function automatic logic [CW-1:0] blank_cycles(input logic [2:0] code);
        unique case (code)
            3'h0: blank_cycles = CW'(BLANK0_CYC);
            3'h1: blank_cycles = CW'(BLANK1_CYC);
            3'h2: blank_cycles = CW'(BLANK2_CYC);
            3'h3: blank_cycles = CW'(BLANK3_CYC);
            3'h4: blank_cycles = CW'(BLANK4_CYC);
            3'h5: blank_cycles = CW'(BLANK5_CYC);
            3'h6: blank_cycles = CW'(BLANK6_CYC);
            3'h7: blank_cycles = CW'(BLANK7_CYC);
        endcase
    endfunction

    // ****************************************
    // serial link
    // ****************************************
    spi_frame_if link_if ();

    spi_frame_shifter u_shifter (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .sck_in(sck_in),
        .cs_low_in(cs_low_in),
        .mosi_in(mosi_in),
        .miso_out(miso_out),
        .miso_oe_out(miso_oe_out),
        .link(link_if.link)
    );

    // ****************************************
    // reset pin synchroniser
    // ****************************************
    logic ext_s1_r, ext_s2_r;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ext_s1_r <= 1'b1;
            ext_s2_r <= 1'b1;
        end else begin
            ext_s1_r <= external_reset_low_in;
            ext_s2_r <= ext_s1_r;
        end
    end

    wire cfg_clear = reset_in | ~ext_s2_r;

    // ****************************************
    // command decode
    // ****************************************
    wire [31:0] rx = link_if.frame_data;
    wire [3:0] rx_code = rx[cfg_frame_pkg::CODE_HI:cfg_frame_pkg::CODE_LO];
    wire parity_ok = rx[cfg_frame_pkg::PARITY_BIT] == parity_of(rx); // see R3
    wire is_ch7 = rx_code == cfg_frame_pkg::CODE_CH7;
    wire is_ch8 = rx_code == cfg_frame_pkg::CODE_CH8; // see R1
    wire cmd_ok = link_if.frame_valid & parity_ok & (is_ch7 | is_ch8);
    wire do_write = cmd_ok & ~rx[cfg_frame_pkg::RW_BIT]; // see R2
    wire wr7 = do_write & is_ch7;
    wire wr8 = do_write & is_ch8;

    // ****************************************
    // configuration images
    // ****************************************
    logic [31:0] cfg7_r, cfg8_r;
    logic resp_valid_r, resp_ch8_r;

    always_ff @(posedge core_clk_in) begin
        if (cfg_clear) begin
            cfg7_r <= cfg_frame_pkg::CH7_RST; // see R22
            cfg8_r <= cfg_frame_pkg::CH8_RST; // see R1, R22
        end else begin
            if (wr7) begin
                cfg7_r <= make_image(cfg_frame_pkg::CODE_CH7, rx);
            end
            if (wr8) begin
                cfg8_r <= make_image(cfg_frame_pkg::CODE_CH8, rx); // see R1
            end
        end
    end

    // answer to the last good command goes out in the next frame
    always_ff @(posedge core_clk_in) begin
        if (cfg_clear) begin
            resp_valid_r <= 1'b0;
            resp_ch8_r <= 1'b0;
        end else if (cmd_ok) begin
            resp_valid_r <= 1'b1;
            resp_ch8_r <= is_ch8;
        end
    end

    assign link_if.tx_word = !resp_valid_r ? cfg_frame_pkg::IDLE_WORD :
                             (resp_ch8_r ? cfg8_r : cfg7_r);

    // ****************************************
    // field outputs
    // ****************************************
    wire [1:0][31:0] img = {cfg8_r, cfg7_r};

    assign second_bridge_enable_out = cfg8_r[cfg_frame_pkg::BRIDGE_BIT];
    assign second_peak_hold_enable_out = cfg8_r[cfg_frame_pkg::PH_BIT];
    assign second_peak_hold_openload_masking_out = cfg8_r[cfg_frame_pkg::MASK_BIT];

    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign tdiag_select_out[c] = 1'b0;
        assign threshold_readback_select_out[c] = img[c][cfg_frame_pkg::RDSEL_BIT]; // see R9
        assign overcurrent_threshold_out[c] =
            img[c][cfg_frame_pkg::THR_HI:cfg_frame_pkg::THR_LO]; // see R10
        assign temperature_compensation_out[c] =
            img[c][cfg_frame_pkg::TCOMP_HI:cfg_frame_pkg::TCOMP_LO]; // see R11
        assign battery_compensation_out[c] = img[c][cfg_frame_pkg::BATT_BIT]; // see R12
        assign overcurrent_blanking_out[c] =
            img[c][cfg_frame_pkg::BLANK_HI:cfg_frame_pkg::BLANK_LO]; // see R13
        assign reengage_strategy_out[c] = img[c][cfg_frame_pkg::REENG_BIT]; // see R15
        assign sense_method_select_out[c] = img[c][cfg_frame_pkg::SENSE_BIT]; // see R16
        assign openload_current_high_out[c] = img[c][cfg_frame_pkg::OLI_BIT]; // see R17
        assign gate_current_select_out[c] =
            img[c][cfg_frame_pkg::GCC_HI:cfg_frame_pkg::GCC_LO]; // see R18
        assign pchannel_select_out[c] = img[c][cfg_frame_pkg::NP_BIT]; // see R19
        assign side_select_out[c] = img[c][cfg_frame_pkg::SIDE_BIT]; // see R20
        assign output_enable_out[c] = img[c][cfg_frame_pkg::EN_BIT]; // see R21
    end

    // ****************************************
    // derived controls, registered
    // ****************************************
    logic [3:0] bridge_group_r, ph_group_r;
    logic no_diag_r;
    logic [1:0] tdiag_active_r, vds_blank_r;
    logic [1:0][CW-1:0] tdiag_cyc_r, blank_cyc_r;

    wire bridge_on = cfg8_r[cfg_frame_pkg::BRIDGE_BIT];
    wire ph_on = cfg8_r[cfg_frame_pkg::PH_BIT];
    wire tdiag_used = ~(bridge_on & ~bridge2_tdiag_ext_in); // see R8

    always_ff @(posedge core_clk_in) begin
        if (cfg_clear) begin
            bridge_group_r <= 4'h0;
            ph_group_r <= 4'h0;
            no_diag_r <= 1'b0;
            tdiag_active_r <= 2'h0;
            vds_blank_r <= 2'h0;
            tdiag_cyc_r <= '0;
            blank_cyc_r <= '0;
        end else begin
            bridge_group_r <= {4{bridge_on}}; // see R4
            ph_group_r <= {4{ph_on}}; // see R6
            no_diag_r <= ph_on & cfg8_r[cfg_frame_pkg::MASK_BIT]; // see R5
            for (int c = 0; c < 2; c++) begin
                tdiag_active_r[c] <= tdiag_used; // see R8
                tdiag_cyc_r[c] <= tdiag_cycles(
                    img[c][cfg_frame_pkg::TDIAG_HI:cfg_frame_pkg::TDIAG_LO]); // see R7
                blank_cyc_r[c] <= blank_cycles(
                    img[c][cfg_frame_pkg::BLANK_HI:cfg_frame_pkg::BLANK_LO]); // see R13
                vds_blank_r[c] <= ~img[c][cfg_frame_pkg::SENSE_BIT]; // see R14
            end
        end
    end

    assign bridge_group_out = bridge_group_r;
    assign peak_hold_group_out = ph_group_r;
    assign openload_no_diag_report_out = no_diag_r;
    assign tdiag_active_out = tdiag_active_r;
    assign tdiag_cycles_out = tdiag_cyc_r;
    assign oc_blank_cycles_out = blank_cyc_r;
    assign vds_blanking_active_out = vds_blank_r;
endmodule
`default_nettype wire

//--- rtl/cfg_frame_pkg.sv
// constants for the channel pair configuration frames
package cfg_frame_pkg;

    // ****************************************
    // frame layout
    // ****************************************
    localparam int FRAME_W = 32;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] FRAME_BITS = 6'h20;
    localparam logic [CNT_W-1:0] CNT_SAT = 6'h21;
    localparam int CODE_HI = 31;
    localparam int CODE_LO = 28;
    localparam int RW_BIT = 27;
    localparam int CFG_HI = 26;
    localparam int CFG_LO = 1;
    localparam int PARITY_BIT = 0;
    localparam logic [3:0] CODE_CH7 = 4'h7;
    localparam logic [3:0] CODE_CH8 = 4'h8;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BRIDGE_BIT = 26;
    localparam int MASK_BIT = 25;
    localparam int PH_BIT = 24;
    localparam int TDIAG_HI = 23;
    localparam int TDIAG_LO = 22;
    localparam int RDSEL_BIT = 21;
    localparam int THR_HI = 20;
    localparam int THR_LO = 15;
    localparam int TCOMP_HI = 14;
    localparam int TCOMP_LO = 13;
    localparam int BATT_BIT = 12;
    localparam int BLANK_HI = 11;
    localparam int BLANK_LO = 9;
    localparam int REENG_BIT = 8;
    localparam int SENSE_BIT = 7;
    localparam int OLI_BIT = 6;
    localparam int GCC_HI = 5;
    localparam int GCC_LO = 4;
    localparam int NP_BIT = 3;
    localparam int SIDE_BIT = 2;
    localparam int EN_BIT = 1;

    // ****************************************
    // reset images
    // ****************************************
    localparam logic [31:0] CH7_RST = 32'h7ac00000;
    localparam logic [31:0] CH8_RST = 32'h88c00001;
    localparam logic [31:0] IDLE_WORD = 32'h00000000;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int TDIAG0_NS = 25600;
    localparam int TDIAG1_NS = 61200;
    localparam int TDIAG2_NS = 105600;
    localparam int TDIAG3_NS = 150000;
    localparam int BLANK0_NS = 11100;
    localparam int BLANK1_NS = 15600;
    localparam int BLANK2_NS = 20000;
    localparam int BLANK3_NS = 31100;
    localparam int BLANK4_NS = 42200;
    localparam int BLANK5_NS = 53300;
    localparam int BLANK6_NS = 97800;
    localparam int BLANK7_NS = 142200;
    localparam int CYC_W = 13;

endpackage

//--- rtl/spi_frame_if.sv
// carrier between the serial shifter and the configuration core
`timescale 1ns/10ps
`default_nettype none
interface spi_frame_if;
    logic frame_valid;
    logic [31:0] frame_data;
    logic [31:0] tx_word;
    modport link (output frame_valid, output frame_data, input tx_word);
    modport core (input frame_valid, input frame_data, output tx_word);
endinterface
`default_nettype wire

//--- rtl/spi_frame_shifter.sv
// 32-bit serial slave shifter, mode 0, msb first
`timescale 1ns/10ps
`default_nettype none
module spi_frame_shifter (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic sck_in,
    input wire logic cs_low_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_out,
    spi_frame_if.link link
);
    logic sck_s1_r, sck_s2_r, sck_s3_r;
    logic cs_s1_r, cs_s2_r, cs_s3_r;
    logic mosi_s1_r, mosi_s2_r;
    logic [31:0] rx_r;
    logic [31:0] tx_r;
    logic [cfg_frame_pkg::CNT_W-1:0] cnt_r;
    logic valid_r;
    logic miso_r;
    logic oe_r;

    wire sck_rise = sck_s2_r & ~sck_s3_r;
    wire sck_fall = ~sck_s2_r & sck_s3_r;
    wire cs_fall = ~cs_s2_r & cs_s3_r;
    wire cs_rise = cs_s2_r & ~cs_s3_r;
    wire active = ~cs_s2_r;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            mosi_s1_r <= 1'b0;
            mosi_s2_r <= 1'b0;
        end else begin
            sck_s1_r <= sck_in;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            cs_s1_r <= cs_low_in;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            mosi_s1_r <= mosi_in;
            mosi_s2_r <= mosi_s1_r;
        end
    end

    // receive side; frames not exactly 32 clocks long are dropped
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rx_r <= cfg_frame_pkg::IDLE_WORD;
            cnt_r <= '0;
            valid_r <= 1'b0;
        end else begin
            valid_r <= cs_rise && (cnt_r == cfg_frame_pkg::FRAME_BITS);
            if (cs_fall) begin
                cnt_r <= '0;
            end else if (active && sck_rise) begin
                rx_r <= {rx_r[30:0], mosi_s2_r};
                if (cnt_r != cfg_frame_pkg::CNT_SAT) begin
                    cnt_r <= cnt_r + 6'h01;
                end
            end
        end
    end

    // transmit side: first bit at select, next ones on falling clock
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            tx_r <= cfg_frame_pkg::IDLE_WORD;
            miso_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            oe_r <= active;
            if (cs_fall) begin
                tx_r <= link.tx_word;
                miso_r <= link.tx_word[31];
            end else if (active && sck_fall) begin
                tx_r <= {tx_r[30:0], 1'b0};
                miso_r <= tx_r[30];
            end
        end
    end

    assign link.frame_valid = valid_r;
    assign link.frame_data = rx_r;
    assign miso_out = miso_r;
    assign miso_oe_out = oe_r;
endmodule
`default_nettype wire

//--- tb/host_model.sv
// serial master model for the host controller
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic clk_in,
    input wire logic miso_in,
    output logic sck_out,
    output logic cs_low_out,
    output logic mosi_out
);
    initial {sck_out, cs_low_out, mosi_out} = 3'h2;
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // mode 0, msb first
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        wait_n(1);
        cs_low_out = 1'b0;
        wait_n(5);
        for (int i = 31; i >= 0; i--) begin
            mosi_out = tx[i];
            wait_n(4);
            sck_out = 1'b1;
            rx[i] = miso_in;
            wait_n(4);
            sck_out = 1'b0;
        end
        wait_n(4);
        cs_low_out = 1'b1;
        // released data line shows the inverse
        mosi_out = ~mosi_out;
        wait_n(4);
    endtask
endmodule
`default_nettype wire

//--- tb/channel_pair_config_frames_sva.sv
// assertions on the top ports
`timescale 1ns/10ps
`default_nettype none
module channel_pair_config_frames_sva (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic external_reset_low_in,
    input wire logic cs_low_in,
    input wire logic bridge2_tdiag_ext_in,
    input wire logic second_bridge_enable_out,
    input wire logic second_peak_hold_enable_out,
    input wire logic second_peak_hold_openload_masking_out,
    input wire logic [3:0] bridge_group_out,
    input wire logic [3:0] peak_hold_group_out,
    input wire logic openload_no_diag_report_out,
    input wire logic [1:0] tdiag_active_out,
    input wire logic [1:0][5:0] overcurrent_threshold_out,
    input wire logic [1:0] sense_method_select_out,
    input wire logic [1:0] vds_blanking_active_out,
    input wire logic [1:0] output_enable_out
);
    logic [1:0] age_r;
    wire logic settled = age_r == 2'h3;
    wire logic ph_and_mask = second_peak_hold_enable_out & second_peak_hold_openload_masking_out;
    wire logic tdiag_off = second_bridge_enable_out & ~bridge2_tdiag_ext_in;
    // pin reset also clears derived outputs, so restart the settle count
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !external_reset_low_in) begin
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    a_bridge_group_copy: assert property (
        settled |-> bridge_group_out == {4{$past(second_bridge_enable_out)}})
        else $error("bridge group wrong");
    a_peak_group_copy: assert property (
        settled |-> peak_hold_group_out == {4{$past(second_peak_hold_enable_out)}})
        else $error("peak group wrong");
    a_openload_report_sel: assert property (
        settled && $stable(ph_and_mask) |-> openload_no_diag_report_out == ph_and_mask)
        else $error("open load report wrong");
    a_tdiag_ignore_cond: assert property (
        settled && $stable(tdiag_off) |-> tdiag_active_out == (tdiag_off ? 2'h0 : 2'h3))
        else $error("diag timer activity wrong");
    a_vds_blanking_mode: assert property (
        settled && $stable(sense_method_select_out) |->
        vds_blanking_active_out == ~sense_method_select_out)
        else $error("blanking mode wrong");
    a_cfg_hold_frame: assert property (
        (!cs_low_in && external_reset_low_in) [*6] |-> $stable(overcurrent_threshold_out)
        && $stable(output_enable_out) && $stable(second_bridge_enable_out))
        else $error("config changed inside a frame");
    a_pin_reset_clear: assert property (
        !external_reset_low_in [*4] |-> output_enable_out == 2'h0
        && overcurrent_threshold_out == '0 && !second_bridge_enable_out)
        else $error("reset pin did not clear config");
    a_outputs_off_reset: assert property (
        disable iff (1'b0) reset_in |=> output_enable_out == 2'h0)
        else $error("outputs on after reset");

    c_tdiag_off: cover property (tdiag_off);
    c_openload_report: cover property (openload_no_diag_report_out);
    c_pin_reset: cover property ($fell(external_reset_low_in));
endmodule
bind channel_pair_config_frames channel_pair_config_frames_sva channel_pair_config_frames_sva_i (
    .core_clk_in, .reset_in, .external_reset_low_in, .cs_low_in, .bridge2_tdiag_ext_in,
    .second_bridge_enable_out, .second_peak_hold_enable_out,
    .second_peak_hold_openload_masking_out, .bridge_group_out, .peak_hold_group_out,
    .openload_no_diag_report_out, .tdiag_active_out, .overcurrent_threshold_out,
    .sense_method_select_out, .vds_blanking_active_out, .output_enable_out);
`default_nettype wire

//--- tb/channel_pair_config_frames_tb_top.sv
// testbench for the channel pair configuration frames
`timescale 1ns/10ps
`default_nettype none
module channel_pair_config_frames_tb_top;
    localparam int P = cfg_frame_pkg::CLK_PERIOD_NS;
    logic core_clk_in, reset_in, external_reset_low_in, bridge2_tdiag_ext_in;
    logic sck_in, cs_low_in, mosi_in, miso_out, miso_oe_out, openload_no_diag_report_out;
    logic second_bridge_enable_out, second_peak_hold_enable_out, second_peak_hold_openload_masking_out;
    logic [3:0] bridge_group_out, peak_hold_group_out;
    logic [1:0] tdiag_select_out, tdiag_active_out, threshold_readback_select_out;
    logic [1:0] battery_compensation_out, vds_blanking_active_out, reengage_strategy_out;
    logic [1:0] sense_method_select_out, openload_current_high_out, pchannel_select_out;
    logic [1:0] side_select_out, output_enable_out;
    logic [1:0][12:0] tdiag_cycles_out, oc_blank_cycles_out;
    logic [1:0][5:0] overcurrent_threshold_out;
    logic [1:0][1:0] temperature_compensation_out, gate_current_select_out;
    logic [1:0][2:0] overcurrent_blanking_out;
    logic [31:0] rx, img8, w;
    int error_cnt = 0;
    int compares = 0;
    int tdc[4] = '{cfg_frame_pkg::TDIAG0_NS / P, cfg_frame_pkg::TDIAG1_NS / P, 40, 60};
    int blc[8] = '{cfg_frame_pkg::BLANK0_NS / P, cfg_frame_pkg::BLANK1_NS / P,
        cfg_frame_pkg::BLANK2_NS / P, cfg_frame_pkg::BLANK3_NS / P, cfg_frame_pkg::BLANK4_NS / P,
        cfg_frame_pkg::BLANK5_NS / P, cfg_frame_pkg::BLANK6_NS / P, 57};

    channel_pair_config_frames #(.TDIAG2_CYC(40), .TDIAG3_CYC(60), .BLANK7_CYC(57))
    channel_pair_config_frames_i (.core_clk_in, .reset_in, .external_reset_low_in, .sck_in,
        .cs_low_in, .mosi_in, .bridge2_tdiag_ext_in, .miso_out, .miso_oe_out,
        .second_bridge_enable_out, .second_peak_hold_enable_out,
        .second_peak_hold_openload_masking_out, .bridge_group_out, .peak_hold_group_out,
        .openload_no_diag_report_out, .tdiag_select_out, .tdiag_active_out, .tdiag_cycles_out,
        .threshold_readback_select_out, .overcurrent_threshold_out,
        .temperature_compensation_out, .battery_compensation_out, .overcurrent_blanking_out,
        .oc_blank_cycles_out, .vds_blanking_active_out, .reengage_strategy_out,
        .sense_method_select_out, .openload_current_high_out, .gate_current_select_out,
        .pchannel_select_out, .side_select_out, .output_enable_out);

    host_model host_model_i (.clk_in(core_clk_in), .miso_in(miso_out), .sck_out(sck_in),
        .cs_low_out(cs_low_in), .mosi_out(mosi_in));

    initial begin
        core_clk_in = 1'b0;
        forever #(P / 2.0) core_clk_in = ~core_clk_in;
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask
    function automatic logic [31:0] fix(input logic [31:0] v);
        return {v[31:1], ~^v[31:1]};
    endfunction
    task automatic send(input logic [31:0] v);
        host_model_i.xfer(v, rx);
        repeat (4) @(negedge core_clk_in);
    endtask
    task automatic chk_ch(input int c, input logic [31:0] v);
        chk("rd_sel", 32'(threshold_readback_select_out[c]), 32'(v[21]));
        chk("threshold", 32'(overcurrent_threshold_out[c]), 32'(v[20:15]));
        chk("temp_comp", 32'(temperature_compensation_out[c]), 32'(v[14:13]));
        chk("batt_comp", 32'(battery_compensation_out[c]), 32'(v[12]));
        chk("blanking", 32'(overcurrent_blanking_out[c]), 32'(v[11:9]));
        chk("reengage", 32'(reengage_strategy_out[c]), 32'(v[8]));
        chk("sense", 32'(sense_method_select_out[c]), 32'(v[7]));
        chk("ol_current", 32'(openload_current_high_out[c]), 32'(v[6]));
        chk("gate_cur", 32'(gate_current_select_out[c]), 32'(v[5:4]));
        chk("pchannel", 32'(pchannel_select_out[c]), 32'(v[3]));
        chk("side", 32'(side_select_out[c]), 32'(v[2]));
        chk("enable", 32'(output_enable_out[c]), 32'(v[1]));
        chk("tdiag_cyc", 32'(tdiag_cycles_out[c]), tdc[v[23:22]]);
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #(P * 80000);
        error_cnt++;
        stop_test();
    end

    initial begin
        reset_in = 1'b1;
        external_reset_low_in = 1'b1;
        bridge2_tdiag_ext_in = 1'b0;
        repeat (6) @(negedge core_clk_in);
        reset_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        chk_ch(0, cfg_frame_pkg::CH7_RST);
        chk_ch(1, cfg_frame_pkg::CH8_RST);
        chk("grp8", 32'({second_bridge_enable_out, second_peak_hold_openload_masking_out,
            second_peak_hold_enable_out}), 32'(cfg_frame_pkg::CH8_RST[26:24]));
        send(fix(32'h88000000));
        chk("rx_first", rx, 32'h00000000);
        img8 = fix(32'h82d5a5f6);
        send(img8);
        chk("rx_rst8", rx, cfg_frame_pkg::CH8_RST);
        chk_ch(1, img8);
        chk_ch(0, cfg_frame_pkg::CH7_RST);
        send(fix(32'h8f000000));
        chk("rx_wr8", rx, fix(img8 | 32'h08000000));
        chk_ch(1, img8);
        send(fix(32'h80000000) ^ 32'h00000001);
        send(fix(32'h50000000));
        chk_ch(1, img8);
        send(fix(32'h78000000));
        chk("rx_kept", rx, fix(img8 | 32'h08000000));
        for (int i = 0; i < 8; i++) begin
            w = fix(32'h70000000 | (32'(i % 4) << 22) | (32'(i) << 9) | (32'(i % 2) << 7));
            send(w);
            if (i == 0) begin
                chk("rx_ch7", rx, fix(cfg_frame_pkg::CH7_RST));
            end
            chk_ch(0, w);
            chk("blank_cyc", 32'(oc_blank_cycles_out[0]), blc[i]);
            chk("vds", 32'(vds_blanking_active_out[0]), 32'(!w[7]));
        end
        send(fix(32'h87000000));
        chk("groups", {bridge_group_out, peak_hold_group_out}, 32'h000000ff);
        chk("ol_report", 32'(openload_no_diag_report_out), 32'h00000001);
        chk("tdiag_off", 32'(tdiag_active_out), 32'h00000000);
        bridge2_tdiag_ext_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        chk("tdiag_on", 32'(tdiag_active_out), 32'h00000003);
        external_reset_low_in = 1'b0;
        repeat (5) @(negedge core_clk_in);
        external_reset_low_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        chk_ch(0, cfg_frame_pkg::CH7_RST);
        chk_ch(1, cfg_frame_pkg::CH8_RST);
        stop_test();
    end
endmodule
`default_nettype wire
